// File: rtl/tick_pkg.sv
// constants for the periodic tick divider and low-power control block
// assumes a plain register port with one-cycle strobes and byte-wide registers
package tick_pkg;
    // register map, byte offsets on the local register port
    localparam logic [3:0] ADDR_LOOP_CTL   = 4'h0;
    localparam logic [3:0] ADDR_TICK_CTL   = 4'h1;
    localparam logic [3:0] ADDR_STATUS     = 4'h2;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h3;
    localparam logic [3:0] ADDR_IRQ_CLEAR  = 4'h4;
    localparam logic [3:0] ADDR_MODE_STAT  = 4'h5;
    // loop control bit positions
    localparam int BIT_TICK_IN_PSTOP = 2;
    localparam int BIT_WDOG_IN_PSTOP = 1;
    localparam int BIT_SELF_CLK_EN   = 0;
    // low-power config bit positions (own register at ADDR_MODE_STAT)
    localparam int BIT_TICK_STOP_WAIT = 1;
    localparam int BIT_WDOG_STOP_WAIT = 0;
    // status bit positions
    localparam int BIT_EV_TICK    = 0;
    localparam int BIT_EV_CM_RST  = 1;
    localparam int BIT_EV_SELFCLK = 2;
    localparam int NUM_EVENTS     = 3;
    // tick control fields
    localparam int PRE_LSB = 4;
    localparam int PRE_MSB = 6;
    localparam int MOD_MSB = 3;
    // reset values
    localparam logic [7:0] LOOP_CTL_RESET = 8'h00;
    localparam logic [7:0] TICK_CTL_RESET = 8'h00;
    localparam logic [2:0] PRE_OFF        = 3'h0;
    // prescale base exponent for code 001
    localparam int PRE_BASE_EXP = 10;
    localparam int PRE_CNT_W    = 16;
    localparam int WDOG_CNT_W   = 24;
    // low-power modes of the part
    typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_PSTOP} power_mode_t;
endpackage

// File: rtl/periodic_tick_divider_control.sv
// periodic tick divider with pseudo-stop, wait and self-clock control bits
// assumes clk_sys is the oscillator clock; power mode and clock fail come
// from other logic on the same clock, so they pass no synchroniser
//
// Notes on behaviour
// - loop control bit 2 keeps tick divider running in pseudo-stop when set
// - tick divider frozen in pseudo-stop holds its count, not cleared
// - loop control bit 1 keeps watchdog divider running in pseudo-stop
// - watchdog divider frozen in pseudo-stop holds count, no reinit
// - self-clock enable: first write only in normal modes, any in special
// - self-clock enable cannot be cleared while self-clock is active
// - clock failure: monitor reset if enable is 0, self-clock if 1
// - every tick control write restarts the tick divider chain
// - tick control readable and writable at any time
// - prescale bits 6:4: 000 off, 001..111 divide by 2^10..2^16
// - modulus bits 3:0 divide by field value plus one
// - tick period equals modulus factor times prescale power of two
// - tick chain counts on the oscillator clock only
// - prescale resets to 000 so the tick is off
// - tick-stop-in-wait set: tick halts and clears on wait entry
// - watchdog-stop-in-wait set: halt and clear; write-once in normal modes
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module periodic_tick_divider_control
(
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic       special_mode,
    input  wire logic [1:0] power_mode,
    input  wire logic       clock_fail,
    output logic            periodic_tick,
    output logic            clock_monitor_reset,
    output logic            self_clock_active,
    output logic            watchdog_tick,
    output logic            irq
);

    logic [7:0]            loop_ctl_q;
    logic [7:0]            tick_ctl_q;
    logic [1:0]            lp_cfg_q;
    logic                  self_clk_written_q;
    logic                  wdog_cfg_written_q;
    logic                  self_clock_active_q;
    logic [tick_pkg::NUM_EVENTS-1:0] status_q;
    logic [tick_pkg::NUM_EVENTS-1:0] irq_en_q;
    logic [tick_pkg::PRE_CNT_W-1:0]  pre_cnt_q;
    logic [3:0]            mod_cnt_q;
    logic [tick_pkg::WDOG_CNT_W-1:0] wdog_cnt_q;
    logic                  periodic_tick_q;
    logic                  cm_reset_q;
    logic [1:0]            mode_prev_q;
    logic [7:0]            reg_rdata_q;

    logic                  wr_loop;
    logic                  wr_tick;
    logic                  wr_lpcfg;
    logic                  in_pstop;
    logic                  in_wait;
    logic                  wait_entry;
    logic [2:0]            pre_sel;
    logic [3:0]            mod_sel;
    logic [tick_pkg::PRE_CNT_W-1:0] pre_last;
    logic                  pre_wrap;
    logic                  tick_run;
    logic                  tick_clear;
    logic                  tick_done;
    logic                  wdog_run;
    logic                  wdog_clear;
    logic                  fail_cm;
    logic                  fail_scm;
    logic [tick_pkg::NUM_EVENTS-1:0] ev_set;
    logic [tick_pkg::NUM_EVENTS-1:0] ev_clr;
    logic                  wr_irq_en;
    logic                  wr_irq_clr;
    logic                  tick_pstop_hold;
    logic                  tick_wait_hold;
    logic                  wdog_pstop_hold;
    logic                  wdog_wait_hold;
    logic                  wdog_tick_q;
    logic [7:0]            rd_mux_d;

    // decode of the register port strobes; reads have no side effects,
    // so only the write strobe is decoded per register
    assign wr_loop    = reg_write && (reg_addr == tick_pkg::ADDR_LOOP_CTL);
    assign wr_tick    = reg_write && (reg_addr == tick_pkg::ADDR_TICK_CTL);
    assign wr_lpcfg   = reg_write && (reg_addr == tick_pkg::ADDR_MODE_STAT);
    assign wr_irq_en  = reg_write && (reg_addr == tick_pkg::ADDR_IRQ_ENABLE);
    assign wr_irq_clr = reg_write && (reg_addr == tick_pkg::ADDR_IRQ_CLEAR);

    // power mode decode; wait entry is the first cycle in wait
    // code 3 is not decoded, so it behaves as run
    assign in_pstop   = (power_mode == tick_pkg::MODE_PSTOP);
    assign in_wait    = (power_mode == tick_pkg::MODE_WAIT);
    assign wait_entry = in_wait && (mode_prev_q != tick_pkg::MODE_WAIT);

    // tick rate fields; bit 7 of the register is not stored
    assign pre_sel = tick_ctl_q[tick_pkg::PRE_MSB:tick_pkg::PRE_LSB];
    assign mod_sel = tick_ctl_q[tick_pkg::MOD_MSB:0];
    // last prescaler count is 2^(9+code)-1, a mask of ones
    assign pre_last = (pre_sel == tick_pkg::PRE_OFF) ? '0 :
        tick_pkg::PRE_CNT_W'((32'h1 << (tick_pkg::PRE_BASE_EXP - 1 + 32'(pre_sel))) - 32'h1);
    assign pre_wrap = (pre_cnt_q == pre_last);

    // run and clear terms of the tick chain; a pseudo-stop hold only
    // freezes the count, while a wait entry with the stop bit clears it
    assign tick_pstop_hold = in_pstop && !loop_ctl_q[tick_pkg::BIT_TICK_IN_PSTOP];
    assign tick_wait_hold  = in_wait && lp_cfg_q[tick_pkg::BIT_TICK_STOP_WAIT];
    assign tick_clear = wr_tick || (wait_entry && lp_cfg_q[tick_pkg::BIT_TICK_STOP_WAIT]);
    assign tick_run   = (pre_sel != tick_pkg::PRE_OFF)
        && !tick_pstop_hold
        && !tick_wait_hold;
    assign tick_done  = tick_run && pre_wrap && (mod_cnt_q == mod_sel);

    // watchdog divider run and clear terms; same split as the tick chain,
    // so a pseudo-stop never restarts the watchdog period
    assign wdog_pstop_hold = in_pstop && !loop_ctl_q[tick_pkg::BIT_WDOG_IN_PSTOP];
    assign wdog_wait_hold  = in_wait && lp_cfg_q[tick_pkg::BIT_WDOG_STOP_WAIT];
    assign wdog_clear = wait_entry && lp_cfg_q[tick_pkg::BIT_WDOG_STOP_WAIT];
    assign wdog_run   = !wdog_pstop_hold
        && !wdog_wait_hold;

    // crystal failure response picks reset or self-clock
    // the enable bit is read as stored, so a failure in the write cycle uses the old value
    assign fail_cm  = clock_fail && !loop_ctl_q[tick_pkg::BIT_SELF_CLK_EN];
    assign fail_scm = clock_fail && loop_ctl_q[tick_pkg::BIT_SELF_CLK_EN];

    // previous power mode for entry detection
    // reset value is run, so a part held in wait through reset still sees an entry
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_prev_q <= tick_pkg::MODE_RUN;
        end
        else
        begin
            mode_prev_q <= power_mode;
        end
    end

    // loop control bits; self-clock enable has its own write guard
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            loop_ctl_q         <= tick_pkg::LOOP_CTL_RESET;
            self_clk_written_q <= 1'b0;
        end
        else if (wr_loop)
        begin
            loop_ctl_q[tick_pkg::BIT_TICK_IN_PSTOP] <= reg_wdata[tick_pkg::BIT_TICK_IN_PSTOP];
            loop_ctl_q[tick_pkg::BIT_WDOG_IN_PSTOP] <= reg_wdata[tick_pkg::BIT_WDOG_IN_PSTOP];
            // once-only in normal modes, clearing blocked in self-clock;
            // any write here uses up the one chance, whatever it holds
            if ((special_mode || !self_clk_written_q)
                && !(self_clock_active_q && !reg_wdata[tick_pkg::BIT_SELF_CLK_EN]))
            begin
                loop_ctl_q[tick_pkg::BIT_SELF_CLK_EN] <= reg_wdata[tick_pkg::BIT_SELF_CLK_EN];
            end
            self_clk_written_q <= 1'b1;
        end
    end

    // tick control register, plain read-write
    // no guard on writes, the counter restart is handled by the chain
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tick_ctl_q <= tick_pkg::TICK_CTL_RESET;
        end
        else if (wr_tick)
        begin
            tick_ctl_q <= {1'b0, reg_wdata[6:0]};
        end
    end

    // wait-mode config; watchdog bit is write-once in normal modes
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lp_cfg_q           <= 2'h0;
            wdog_cfg_written_q <= 1'b0;
        end
        else if (wr_lpcfg)
        begin
            lp_cfg_q[tick_pkg::BIT_TICK_STOP_WAIT] <= reg_wdata[tick_pkg::BIT_TICK_STOP_WAIT];
            // locking the watchdog bit keeps stray code from disarming it
            if (special_mode || !wdog_cfg_written_q)
            begin
                lp_cfg_q[tick_pkg::BIT_WDOG_STOP_WAIT] <= reg_wdata[tick_pkg::BIT_WDOG_STOP_WAIT];
            end
            wdog_cfg_written_q <= 1'b1;
        end
    end

    // prescaler and modulus counter on the oscillator clock
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pre_cnt_q <= '0;
            mod_cnt_q <= 4'h0;
        end
        else if (tick_clear || tick_done)
        begin
            pre_cnt_q <= '0;
            mod_cnt_q <= 4'h0;
        end
        else if (tick_run)
        begin
            // freezing keeps the count so pseudo-stop resumes mid-period
            if (pre_wrap)
            begin
                pre_cnt_q <= '0;
                mod_cnt_q <= mod_cnt_q + 4'h1;
            end
            else
            begin
                pre_cnt_q <= pre_cnt_q + 1'b1;
            end
        end
    end

    // watchdog divider, handed to the watchdog as its carry output
    // it counts outside the pseudo-stop and wait holds; rate selection lives in the watchdog itself
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wdog_cnt_q <= '0;
        end
        else if (wdog_clear)
        begin
            wdog_cnt_q <= '0;
        end
        else if (wdog_run)
        begin
            wdog_cnt_q <= wdog_cnt_q + 1'b1;
        end
    end

    // carry registered so the consumer never sees a wide and-gate glitch
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wdog_tick_q <= 1'b0;
        end
        else
        begin
            wdog_tick_q <= &wdog_cnt_q;
        end
    end
    assign watchdog_tick = wdog_tick_q;

    // tick pulse output from a flop
    // one cycle late against the wrap, traded for a glitch-free pulse
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            periodic_tick_q <= 1'b0;
        end
        else
        begin
            periodic_tick_q <= tick_done;
        end
    end
    assign periodic_tick = periodic_tick_q;

    // self-clock mode latch; left only through reset, as the part restarts
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            self_clock_active_q <= 1'b0;
        end
        else if (fail_scm)
        begin
            self_clock_active_q <= 1'b1;
        end
    end

    // monitor reset request, high as long as the failure is reported
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cm_reset_q <= 1'b0;
        end
        else
        begin
            cm_reset_q <= fail_cm;
        end
    end
    assign self_clock_active   = self_clock_active_q;
    assign clock_monitor_reset = cm_reset_q;

    // sticky events; a set in the clearing cycle wins
    assign ev_set[tick_pkg::BIT_EV_TICK]    = tick_done;
    assign ev_set[tick_pkg::BIT_EV_CM_RST]  = fail_cm;
    assign ev_set[tick_pkg::BIT_EV_SELFCLK] = fail_scm && !self_clock_active_q;
    assign ev_clr = wr_irq_clr ? reg_wdata[tick_pkg::NUM_EVENTS-1:0] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < tick_pkg::NUM_EVENTS; gi = gi + 1)
        begin : g_ev
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    status_q[gi] <= 1'b0;
                end
                else if (ev_set[gi])
                begin
                    status_q[gi] <= 1'b1;
                end
                else if (ev_clr[gi])
                begin
                    status_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // interrupt enable register
    // masking hides the request but leaves the sticky status untouched
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_en_q <= '0;
        end
        else if (wr_irq_en)
        begin
            irq_en_q <= reg_wdata[tick_pkg::NUM_EVENTS-1:0];
        end
    end
    assign irq = |(status_q & irq_en_q);

    // read multiplexer; unmapped and write-only offsets read as zero,
    // which also keeps the clear register from echoing its last write
    always_comb
    begin
        rd_mux_d = 8'h00;
        case (reg_addr)
            tick_pkg::ADDR_LOOP_CTL:   rd_mux_d = {5'h00, loop_ctl_q[2:0]};
            tick_pkg::ADDR_TICK_CTL:   rd_mux_d = tick_ctl_q;
            tick_pkg::ADDR_STATUS:     rd_mux_d = {5'h00, status_q};
            tick_pkg::ADDR_IRQ_ENABLE: rd_mux_d = {5'h00, irq_en_q};
            tick_pkg::ADDR_MODE_STAT:  rd_mux_d = {5'h00, self_clock_active_q, lp_cfg_q};
            default:                   rd_mux_d = 8'h00;
        endcase
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rdata_q <= 8'h00;
        end
        else if (reg_read)
        begin
            reg_rdata_q <= rd_mux_d;
        end
        else
        begin
            reg_rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = reg_rdata_q;

endmodule
`default_nettype wire

// File: verif/tick_ctl_sva.sv
// assertions on the ports of the periodic tick divider block
// assumes one clock, clk_sys, and the async active-low reset arst_n
`timescale 1ns/100ps
`default_nettype none
module tick_ctl_sva
(
    input wire logic       clk_sys,
    input wire logic       arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       clock_fail,
    input wire logic       periodic_tick,
    input wire logic       clock_monitor_reset,
    input wire logic       self_clock_active
);
    logic        wr_q;
    logic [2:0]  pre_q;
    logic [11:0] gap_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // shadow of the last tick write; a pulse in the cycle after the write strobe is tolerated
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_q  <= 1'b0;
            pre_q <= 3'h0;
        end
        else
        begin
            wr_q <= reg_write && reg_addr == tick_pkg::ADDR_TICK_CTL;
            if (reg_write && reg_addr == tick_pkg::ADDR_TICK_CTL)
                pre_q <= reg_wdata[6:4];
        end
    end
    // cycles since last tick or restart, saturating so it never wraps to a short gap
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            gap_q <= 12'h000;
        else if (periodic_tick || wr_q)
            gap_q <= 12'h000;
        else if (gap_q != 12'hfff)
            gap_q <= gap_q + 12'h001;
    end
    chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    chk_clear_reads_zero: assert property ($past(reg_read) &&
        $past(reg_addr) == tick_pkg::ADDR_IRQ_CLEAR |-> reg_rdata == 8'h00)
        else $error("clear register read not zero");
    chk_tick_single: assert property (periodic_tick |=> !periodic_tick)
        else $error("tick pulse longer than one cycle");
    chk_tick_off: assert property (periodic_tick && !wr_q |-> pre_q != 3'h0)
        else $error("tick while prescale off");
    chk_tick_gap: assert property (periodic_tick && !wr_q |-> gap_q >= 12'h3ff)
        else $error("tick period shorter than minimum");
    chk_cmr_cause: assert property ($rose(clock_monitor_reset) |->
        $past(clock_fail) && !self_clock_active)
        else $error("monitor reset without clock failure");
    chk_self_clk_cause: assert property ($rose(self_clock_active) |-> $past(clock_fail))
        else $error("self-clock without clock failure");
    chk_self_clk_hold: assert property (self_clock_active |=> self_clock_active)
        else $error("self-clock dropped without reset");
endmodule
bind periodic_tick_divider_control tick_ctl_sva u_sva (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .clock_fail(clock_fail), .periodic_tick(periodic_tick),
    .clock_monitor_reset(clock_monitor_reset), .self_clock_active(self_clock_active));
`default_nettype wire

// File: verif/tb_periodic_tick_divider_control.sv
// self-checking bench for the periodic tick divider block
// assumes the register map of tick_pkg and a 50 ns clock
`timescale 1ns/100ps
`default_nettype none
module tb_periodic_tick_divider_control;
    logic       clk_sys = 1'b0;
    logic       arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_write = 1'b0;
    logic       reg_read = 1'b0;
    logic       special_mode = 1'b0;
    logic [1:0] power_mode = 2'h0;
    logic       clock_fail = 1'b0;
    logic [7:0] reg_rdata;
    logic       periodic_tick;
    logic       clock_monitor_reset;
    logic       self_clock_active;
    logic       irq;
    logic       wd_tick;
    logic [7:0] rv;
    int         err_count = 0;
    int         comparisons = 0;
    always #25 clk_sys = ~clk_sys;
    periodic_tick_divider_control dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .special_mode(special_mode), .power_mode(power_mode),
        .clock_fail(clock_fail), .periodic_tick(periodic_tick),
        .clock_monitor_reset(clock_monitor_reset), .self_clock_active(self_clock_active),
        .watchdog_tick(wd_tick), .irq(irq));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_n(input string nm, input int e, input int g);
        comparisons++;
        if (g != e)
        begin
            err_count++;
            $display("mismatch %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic fail_pulse();
        @(posedge clk_sys);
        clock_fail <= 1'b1;
        @(posedge clk_sys);
        clock_fail <= 1'b0;
        #1;
    endtask
    // cycles from a tick write to its first pulse, power mode pm held for len cycles
    task automatic measure(input logic [7:0] v, input int st, input int len,
                           input logic [1:0] pm, input int e);
        int n;
        wr(tick_pkg::ADDR_TICK_CTL, v);
        for (n = 1; n <= e + 20; n++)
        begin
            @(posedge clk_sys);
            power_mode <= (n > st && n <= st + len) ? pm : 2'h0;
            #1 if (periodic_tick === 1'b1) break;
        end
        power_mode <= 2'h0;
        chk_n("tick period", e, n);
    endtask
    task automatic t_reset_and_once();
        rd(tick_pkg::ADDR_TICK_CTL);
        chk("tick ctl reset", 8'h00, rv);
        chk("watchdog carry", 8'h00, {7'h00, wd_tick});
        wr(tick_pkg::ADDR_TICK_CTL, 8'hff);
        rd(tick_pkg::ADDR_TICK_CTL);
        chk("tick ctl readback", 8'h7f, rv);
        wr(tick_pkg::ADDR_LOOP_CTL, 8'h00);
        wr(tick_pkg::ADDR_LOOP_CTL, 8'h01);
        rd(tick_pkg::ADDR_LOOP_CTL);
        chk("second write ignored", 8'h00, rv);
        fail_pulse();
        chk("monitor reset", 8'h01, {7'h00, clock_monitor_reset});
    endtask
    task automatic t_rates_irq();
        int hits;
        measure(8'h10, 0, 0, 2'h0, 1024);
        measure(8'h11, 0, 0, 2'h0, 2048);
        measure(8'h20, 0, 0, 2'h0, 2048);
        measure(8'h13, 0, 0, 2'h0, 4096);
        wr(tick_pkg::ADDR_IRQ_CLEAR, 8'h07);
        measure(8'h10, 0, 0, 2'h0, 1024);
        rd(tick_pkg::ADDR_STATUS);
        chk("tick status", 8'h01, rv);
        wr(tick_pkg::ADDR_IRQ_ENABLE, 8'h01);
        chk("irq enabled", 8'h01, {7'h00, irq});
        wr(tick_pkg::ADDR_IRQ_ENABLE, 8'h00);
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(tick_pkg::ADDR_IRQ_CLEAR, 8'h01);
        rd(tick_pkg::ADDR_STATUS);
        chk("status cleared", 8'h00, rv);
        rd(4'hf);
        chk("unmapped read", 8'h00, rv);
        rd(tick_pkg::ADDR_IRQ_CLEAR);
        chk("clear reg read", 8'h00, rv);
        wr(tick_pkg::ADDR_TICK_CTL, 8'h05);
        hits = 0;
        repeat (1100)
        begin
            @(posedge clk_sys);
            #1 hits += (periodic_tick === 1'b1);
        end
        chk_n("ticks while off", 0, hits);
    endtask
    // special mode lifts the once-only guard on the self-clock enable from here on
    task automatic t_low_power();
        special_mode <= 1'b1;
        wr(tick_pkg::ADDR_LOOP_CTL, 8'h00);
        measure(8'h10, 400, 1000, 2'h2, 2024);
        wr(tick_pkg::ADDR_LOOP_CTL, 8'h04);
        measure(8'h10, 400, 1000, 2'h2, 1024);
        wr(tick_pkg::ADDR_MODE_STAT, 8'h02);
        measure(8'h10, 400, 100, 2'h1, 1525);
        wr(tick_pkg::ADDR_MODE_STAT, 8'h00);
        measure(8'h10, 400, 100, 2'h1, 1024);
    endtask
    task automatic t_self_clock();
        wr(tick_pkg::ADDR_LOOP_CTL, 8'h05);
        rd(tick_pkg::ADDR_LOOP_CTL);
        chk("special write", 8'h05, rv);
        fail_pulse();
        chk("self-clock on", 8'h01, {7'h00, self_clock_active});
        chk("no monitor reset", 8'h00, {7'h00, clock_monitor_reset});
        wr(tick_pkg::ADDR_LOOP_CTL, 8'h04);
        rd(tick_pkg::ADDR_LOOP_CTL);
        chk("enable kept", 8'h05, rv);
    endtask
    task automatic complete_run();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_reset_and_once();
        t_rates_irq();
        t_low_power();
        t_self_clock();
        complete_run();
    end
    // hang guard well above the expected run length
    initial
    begin
        #4000000;
        err_count++;
        complete_run();
    end
endmodule
`default_nettype wire
